//--- src/subroutine_interrupt_linkage.v
// linkage sequencer for calls, returns, jumps and interrupt entry and exit
// Overview of operation
// - a call first pushes the linkage register onto the register-six stack by predecrement.
// - a call then loads the linkage register with the program counter and jumps to the entry.
// - an autoincrement argument fetch through the linkage register advances it past the word.
// - a return copies the named register to the program counter then pops the stack into it.
// - a plain jump only loads the program counter, with no push and no register load.
// - interrupt entry pushes the status word first and the program counter second.
// - interrupt entry then reads two consecutive vector words for a new counter and status.
// - the lower vector word is the routine address and the next word the new status word.
// - the status word from the vector sets the operating mode and register set outputs.
// - return from service pops the program counter and then the status word.
// - the stack grows downward: pushes predecrement and pops postincrement.
// - the system stack pointer is always even and steps by two bytes, except when a call or return names register six and loads it.
`timescale 1ns/1ps
`include "linkage_defines.vh"
module subroutine_interrupt_linkage
(
  // clock and reset
  input  wire        core_clk,
  input  wire        rstn,
  // instruction request from the decoder
  input  wire        op_valid,
  input  wire [2:0]  op_code,
  input  wire [2:0]  op_reg,
  input  wire [15:0] op_target,
  output wire        op_ready,
  // interrupt request with its vector address
  input  wire        irq_req,
  input  wire [15:0] irq_vector,
  output wire        irq_ack,
  // architectural state
  output reg  [15:0] pc_q,
  output reg  [15:0] processor_status_word_q,
  output reg  [15:0] sp_q,
  output reg  [15:0] link_val_q,
  output reg  [15:0] arg_data_q,
  output wire [1:0]  run_mode,
  output wire        reg_set,
  // memory
  output wire        mem_req,
  output wire        mem_we,
  output wire [15:0] mem_addr,
  output wire [15:0] mem_wdata,
  input  wire        mem_ack,
  input  wire [15:0] mem_rdata
);
  // ***********************************************
  // states
  // ***********************************************
  localparam S_IDLE     = 4'h0;
  localparam S_CALL_PSH = 4'h1;
  localparam S_RET_POP  = 4'h2;
  localparam S_INT_PSW  = 4'h3;
  localparam S_INT_PC   = 4'h4;
  localparam S_VEC_PC   = 4'h5;
  localparam S_VEC_PSW  = 4'h6;
  localparam S_RTI_PC   = 4'h7;
  localparam S_RTI_PSW  = 4'h8;
  localparam S_ARG      = 4'h9;
  localparam S_WAIT     = 4'hA;

  // ***********************************************
  // general registers held here, stack and pc apart
  // ***********************************************
  reg  [15:0] gpr_q [0:5];
  reg  [3:0]  state_q;
  reg  [3:0]  next_q;
  reg  [2:0]  reg_sel_q;
  reg  [15:0] target_q;
  reg  [15:0] vec_q;
  reg         mp_start;
  reg         mp_write;
  reg  [15:0] mp_addr;
  reg  [15:0] mp_wdata;
  wire        mp_done;
  wire [15:0] mp_rdata;
  wire [15:0] sp_down;
  wire [15:0] sp_up;
  integer     i;

  // reads one general register, pc and sp included
  function [15:0] reg_read;
    input [2:0]  idx;
    input [15:0] pc_v;
    input [15:0] sp_v;
    input [15:0] g0;
    input [15:0] g1;
    input [15:0] g2;
    input [15:0] g3;
    input [15:0] g4;
    input [15:0] g5;
    begin
      case (idx)
        3'h0:    reg_read = g0;
        3'h1:    reg_read = g1;
        3'h2:    reg_read = g2;
        3'h3:    reg_read = g3;
        3'h4:    reg_read = g4;
        3'h5:    reg_read = g5;
        3'h6:    reg_read = sp_v;
        default: reg_read = pc_v;
      endcase
    end
  endfunction

  wire [15:0] sel_val = reg_read(reg_sel_q, pc_q, sp_q, gpr_q[0], gpr_q[1], gpr_q[2],
                                 gpr_q[3], gpr_q[4], gpr_q[5]);

  // ***********************************************
  // helpers
  // ***********************************************
  word_adjust u_down
  (
    .value_in  (sp_q),
    .step_down (1'b1),
    .value_out (sp_down)
  );

  word_adjust u_up
  (
    .value_in  (sp_q),
    .step_down (1'b0),
    .value_out (sp_up)
  );

  mem_port u_mem
  (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .start     (mp_start),
    .write     (mp_write),
    .addr      (mp_addr),
    .wdata     (mp_wdata),
    .mem_req   (mem_req),
    .mem_we    (mem_we),
    .mem_addr  (mem_addr),
    .mem_wdata (mem_wdata),
    .mem_ack   (mem_ack),
    .mem_rdata (mem_rdata),
    .done      (mp_done),
    .rdata     (mp_rdata)
  );

  // handshakes: interrupts win only at an instruction boundary
  assign irq_ack  = (state_q == S_IDLE) && irq_req;
  assign op_ready = (state_q == S_IDLE) && !irq_req;
  // status fields steer mode and register set
  assign run_mode = processor_status_word_q[`PSW_MODE_MSB:`PSW_MODE_LSB];
  assign reg_set  = processor_status_word_q[`PSW_SET_BIT];

  // ***********************************************
  // sequencer
  // ***********************************************
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q                 <= S_IDLE;
      next_q                  <= S_IDLE;
      reg_sel_q               <= 3'h0;
      target_q                <= `REG_RESET;
      vec_q                   <= `REG_RESET;
      pc_q                    <= `REG_RESET;
      sp_q                    <= `REG_RESET;
      processor_status_word_q <= `PSW_RESET;
      link_val_q              <= `REG_RESET;
      arg_data_q              <= `REG_RESET;
      mp_start                <= 1'b0;
      mp_write                <= 1'b0;
      mp_addr                 <= `REG_RESET;
      mp_wdata                <= `REG_RESET;
      for (i = 0; i < 6; i = i + 1)
        gpr_q[i] <= `REG_RESET;
    end
    else
    begin
      mp_start <= 1'b0;
      case (state_q)
        S_IDLE:
        begin
          if (irq_req)
          begin
            // pointer drops before the status write is issued
            vec_q    <= irq_vector & `EVEN_MASK;
            sp_q     <= sp_down;
            mp_addr  <= sp_down;
            mp_wdata <= processor_status_word_q;
            mp_write <= 1'b1;
            mp_start <= 1'b1;
            state_q  <= S_WAIT;
            next_q   <= S_INT_PSW;
          end
          else if (op_valid)
          begin
            reg_sel_q <= op_reg;
            target_q  <= op_target;
            case (op_code)
              `OP_CALL:
              begin
                // push the linkage register as a predecrement store
                sp_q     <= sp_down;
                mp_addr  <= sp_down;
                mp_wdata <= reg_read(op_reg, pc_q, sp_down, gpr_q[0], gpr_q[1],
                                     gpr_q[2], gpr_q[3], gpr_q[4], gpr_q[5]);
                mp_write <= 1'b1;
                mp_start <= 1'b1;
                state_q  <= S_WAIT;
                next_q   <= S_CALL_PSH;
              end
              `OP_RETURN:
              begin
                // named register moves to pc, then the pop follows
                pc_q     <= reg_read(op_reg, pc_q, sp_q, gpr_q[0], gpr_q[1],
                                     gpr_q[2], gpr_q[3], gpr_q[4], gpr_q[5]);
                mp_addr  <= sp_q;
                mp_write <= 1'b0;
                mp_start <= 1'b1;
                state_q  <= S_WAIT;
                next_q   <= S_RET_POP;
              end
              `OP_JUMP:
                pc_q <= op_target;
              `OP_SERVICE_RT:
              begin
                mp_addr  <= sp_q;
                mp_write <= 1'b0;
                mp_start <= 1'b1;
                state_q  <= S_WAIT;
                next_q   <= S_RTI_PC;
              end
              `OP_ARG_FETCH:
              begin
                mp_addr  <= reg_read(op_reg, pc_q, sp_q, gpr_q[0], gpr_q[1],
                                     gpr_q[2], gpr_q[3], gpr_q[4], gpr_q[5]);
                mp_write <= 1'b0;
                mp_start <= 1'b1;
                state_q  <= S_WAIT;
                next_q   <= S_ARG;
              end
              default:
                state_q <= S_IDLE;
            endcase
          end
        end
        S_WAIT:
          if (mp_done)
            state_q <= next_q;
        S_CALL_PSH:
        begin
          // link register takes the return address, pc takes the entry
          case (reg_sel_q)
            `PC_INDEX: link_val_q <= pc_q;
            `SP_INDEX: sp_q <= pc_q & `EVEN_MASK;
            default:   gpr_q[reg_sel_q] <= pc_q;
          endcase
          if (reg_sel_q != `PC_INDEX)
            link_val_q <= pc_q;
          pc_q    <= target_q;
          state_q <= S_IDLE;
        end
        S_RET_POP:
        begin
          // pointer rises only after the read has completed
          sp_q <= sp_up;
          case (reg_sel_q)
            `PC_INDEX: pc_q <= mp_rdata;
            `SP_INDEX: sp_q <= mp_rdata & `EVEN_MASK;
            default:   gpr_q[reg_sel_q] <= mp_rdata;
          endcase
          link_val_q <= mp_rdata;
          state_q    <= S_IDLE;
        end
        S_INT_PSW:
        begin
          // second push carries the program counter
          sp_q     <= sp_down;
          mp_addr  <= sp_down;
          mp_wdata <= pc_q;
          mp_write <= 1'b1;
          mp_start <= 1'b1;
          state_q  <= S_WAIT;
          next_q   <= S_INT_PC;
        end
        S_INT_PC:
        begin
          // lower vector word first
          mp_addr  <= vec_q;
          mp_write <= 1'b0;
          mp_start <= 1'b1;
          state_q  <= S_WAIT;
          next_q   <= S_VEC_PC;
        end
        S_VEC_PC:
        begin
          pc_q     <= mp_rdata;
          mp_addr  <= vec_q + `WORD_STEP;
          mp_write <= 1'b0;
          mp_start <= 1'b1;
          state_q  <= S_WAIT;
          next_q   <= S_VEC_PSW;
        end
        S_VEC_PSW:
        begin
          processor_status_word_q <= mp_rdata;
          state_q                 <= S_IDLE;
        end
        S_RTI_PC:
        begin
          pc_q     <= mp_rdata;
          sp_q     <= sp_up;
          mp_addr  <= sp_up;
          mp_write <= 1'b0;
          mp_start <= 1'b1;
          state_q  <= S_WAIT;
          next_q   <= S_RTI_PSW;
        end
        S_RTI_PSW:
        begin
          processor_status_word_q <= mp_rdata;
          sp_q                    <= sp_up;
          state_q                 <= S_IDLE;
        end
        S_ARG:
        begin
          // autoincrement advances the linkage register to the next word
          arg_data_q <= mp_rdata;
          case (reg_sel_q)
            `PC_INDEX: pc_q <= sel_val + `WORD_STEP;
            `SP_INDEX: sp_q <= sp_up;
            default:   gpr_q[reg_sel_q] <= sel_val + `WORD_STEP;
          endcase
          state_q <= S_IDLE;
        end
        default:
          state_q <= S_IDLE;
      endcase
    end
  end
endmodule

//--- src/linkage_defines.vh
// constants for the subroutine and interrupt linkage sequencer
`ifndef LINKAGE_DEFINES_VH
`define LINKAGE_DEFINES_VH
`define WORD_W        16
`define WORD_STEP     16'h0002
`define SP_INDEX      3'h6
`define PC_INDEX      3'h7
`define EVEN_MASK     16'hFFFE
`define REG_RESET     16'h0000
`define PSW_RESET     16'h0000
`define OP_NONE       3'h0
`define OP_CALL       3'h1
`define OP_RETURN     3'h2
`define OP_JUMP       3'h3
`define OP_SERVICE_RT 3'h4
`define OP_ARG_FETCH  3'h5
`define PSW_MODE_LSB  14
`define PSW_MODE_MSB  15
`define PSW_SET_BIT   11
`endif

//--- src/word_adjust.v
// stack pointer step arithmetic, whole words only
`timescale 1ns/1ps
module word_adjust
(
  // operand and direction
  input  wire [15:0] value_in,
  input  wire        step_down,
  // result
  output wire [15:0] value_out
);
  // predecrement or postincrement by two, kept on an even address
  assign value_out = step_down ? ((value_in - 16'h0002) & 16'hFFFE)
                               : ((value_in + 16'h0002) & 16'hFFFE);
endmodule

//--- src/mem_port.v
// single outstanding memory word access with a done pulse
`timescale 1ns/1ps
module mem_port
(
  // clock and reset
  input  wire        core_clk,
  input  wire        rstn,
  // request from the sequencer
  input  wire        start,
  input  wire        write,
  input  wire [15:0] addr,
  input  wire [15:0] wdata,
  // memory side
  output reg         mem_req,
  output reg         mem_we,
  output reg  [15:0] mem_addr,
  output reg  [15:0] mem_wdata,
  input  wire        mem_ack,
  input  wire [15:0] mem_rdata,
  // completion
  output reg         done,
  output reg  [15:0] rdata
);
  // hold the request until memory acknowledges
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= 16'h0000;
      mem_wdata <= 16'h0000;
      done      <= 1'b0;
      rdata     <= 16'h0000;
    end
    else
    begin
      done <= 1'b0;
      if (mem_req && mem_ack)
      begin
        mem_req <= 1'b0;
        mem_we  <= 1'b0;
        done    <= 1'b1;
        rdata   <= mem_rdata;
      end
      else if (start && !mem_req)
      begin
        mem_req   <= 1'b1;
        mem_we    <= write;
        mem_addr  <= addr;
        mem_wdata <= wdata;
      end
    end
  end
endmodule

//--- bench/linkage_sva.sv
// checker for the linkage sequencer port behaviour
`timescale 1ns/1ps
`include "linkage_defines.vh"
module linkage_sva
(
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rstn,
  // requests
  input wire logic        op_valid,
  input wire logic [2:0]  op_code,
  input wire logic [15:0] op_target,
  input wire logic        op_ready,
  input wire logic        irq_req,
  input wire logic        irq_ack,
  // state and memory
  input wire logic [15:0] pc_q,
  input wire logic [15:0] processor_status_word_q,
  input wire logic [15:0] sp_q,
  input wire logic [1:0]  run_mode,
  input wire logic        reg_set,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic        mem_ack
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // ****************************************
  // ordering and stack shape
  // ****************************************
  irq_block_a: assert property (irq_req |-> !op_ready)
    else $error("request accepted while interrupt pending");
  ack_cause_a: assert property (irq_ack |-> irq_req)
    else $error("interrupt taken without request");
  sp_even_a: assert property (sp_q[0] == 1'b0)
    else $error("stack pointer odd");
  sp_step_a: assert property (sp_q != $past(sp_q) |->
    (sp_q - $past(sp_q) == `WORD_STEP || $past(sp_q) - sp_q == `WORD_STEP))
    else $error("stack pointer step not two");
  push_addr_a: assert property (mem_req && mem_we |-> mem_addr == sp_q)
    else $error("push not at decremented pointer");
  req_hold_a: assert property (mem_req && !mem_ack |=>
    mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request changed before ack");
  mode_map_a: assert property (run_mode == processor_status_word_q[15:14]
    && reg_set == processor_status_word_q[11])
    else $error("mode outputs differ from status word");
  jump_only_a: assert property (op_valid && op_ready && op_code == `OP_JUMP |=>
    pc_q == $past(op_target) && sp_q == $past(sp_q) && !mem_req)
    else $error("plain jump wrong");
  call_push_a: assert property (op_valid && op_ready && op_code == `OP_CALL |=>
    sp_q == $past(sp_q) - `WORD_STEP)
    else $error("call did not predecrement pointer");
endmodule
bind subroutine_interrupt_linkage linkage_sva linkage_sva_i (.core_clk(core_clk),
  .rstn(rstn), .op_valid(op_valid), .op_code(op_code), .op_target(op_target),
  .op_ready(op_ready), .irq_req(irq_req), .irq_ack(irq_ack), .pc_q(pc_q),
  .processor_status_word_q(processor_status_word_q), .sp_q(sp_q),
  .run_mode(run_mode), .reg_set(reg_set), .mem_req(mem_req), .mem_we(mem_we),
  .mem_addr(mem_addr), .mem_ack(mem_ack));

//--- bench/word_memory.sv
// main memory model with adjustable answer delay
`timescale 1ns/1ps
module word_memory
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // access
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  input  wire logic [3:0]  delay,
  output logic             mem_ack,
  output logic [15:0]      mem_rdata
);
  logic [15:0] words [0:255];
  logic [3:0]  cnt_q;
  initial for (int i = 0; i < 256; i++) words[i] = 16'h5A5A;
  // answer after delay; data toggles when not valid
  always @(posedge core_clk or negedge rstn)
    if (!rstn)
    begin
      mem_ack   <= 1'b0;
      cnt_q     <= 4'h0;
      mem_rdata <= 16'hA5A5;
    end
    else if (mem_req && !mem_ack && cnt_q >= delay)
    begin
      mem_ack <= 1'b1;
      cnt_q   <= 4'h0;
      if (mem_we) words[mem_addr[8:1]] <= mem_wdata;
      mem_rdata <= mem_we ? ~mem_rdata : words[mem_addr[8:1]];
    end
    else
    begin
      mem_ack   <= 1'b0;
      cnt_q     <= (mem_req && !mem_ack) ? cnt_q + 4'h1 : 4'h0;
      mem_rdata <= ~mem_rdata;
    end
endmodule

//--- bench/subroutine_interrupt_linkage_test.sv
// testbench for the linkage sequencer
`timescale 1ns/1ps
`include "linkage_defines.vh"
module subroutine_interrupt_linkage_test;
  logic core_clk, rstn, op_valid, irq_req, op_ready, irq_ack, reg_set;
  logic mem_req, mem_we, mem_ack;
  logic [2:0] op_code, op_reg;
  logic [1:0] run_mode;
  logic [3:0] mem_delay;
  logic [15:0] op_target, irq_vector, pc_q, psw, sp_q, link_val_q, arg_data_q;
  logic [15:0] mem_addr, mem_wdata, mem_rdata;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  subroutine_interrupt_linkage subroutine_interrupt_linkage_i (.core_clk(core_clk),
    .rstn(rstn), .op_valid(op_valid), .op_code(op_code), .op_reg(op_reg),
    .op_target(op_target), .op_ready(op_ready), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_ack(irq_ack), .pc_q(pc_q),
    .processor_status_word_q(psw), .sp_q(sp_q), .link_val_q(link_val_q),
    .arg_data_q(arg_data_q), .run_mode(run_mode), .reg_set(reg_set),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  word_memory word_memory_i (.core_clk(core_clk), .rstn(rstn), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .delay(mem_delay),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  // clock and hang guard
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // wait at falling edges until a request can be taken
  task automatic wait_idle();
    int n;
    n = 0;
    @(negedge core_clk);
    while (op_ready !== 1'b1 && n < 200)
    begin
      @(negedge core_clk);
      n++;
    end
    chk({15'h0, op_ready}, 16'h0001);
  endtask
  task automatic issue(input logic [2:0] c, input logic [2:0] r, input logic [15:0] t);
    op_code = c;
    op_reg = r;
    op_target = t;
    op_valid = 1'b1;
    @(posedge core_clk);
    @(negedge core_clk);
    op_valid = 1'b0;
    wait_idle();
  endtask
  task automatic t_jump();
    issue(`OP_JUMP, 3'h0, 16'h0400);
    chk(pc_q, 16'h0400);
    issue(`OP_JUMP, 3'h0, 16'h0200);
    chk(pc_q, 16'h0200);
    chk(sp_q, 16'h0000);
  endtask
  task automatic t_call();
    word_memory_i.words[0] = 16'h1234;
    issue(`OP_CALL, 3'h5, 16'h0100);
    chk(word_memory_i.words[255], 16'h0000);
    chk(sp_q, 16'hFFFE);
    chk(link_val_q, 16'h0200);
    chk(pc_q, 16'h0100);
    issue(`OP_ARG_FETCH, 3'h5, 16'h0000);
    chk(arg_data_q, 16'h1234);
    issue(`OP_RETURN, 3'h5, 16'h0000);
    chk(pc_q, 16'h0202);
    chk(link_val_q, 16'h0000);
    chk(sp_q, 16'h0000);
  endtask
  task automatic t_irq();
    int n;
    n = 0;
    mem_delay = 4'h3;
    // a stale top word so that the status push is visible
    word_memory_i.words[255] = 16'hFFFF;
    word_memory_i.words[32] = 16'h0300;
    word_memory_i.words[33] = 16'hC800;
    irq_vector = 16'h0040;
    irq_req = 1'b1;
    // let the combinational acknowledge settle before looking at it
    #1;
    while (irq_ack !== 1'b1 && n < 50)
    begin
      @(negedge core_clk);
      n++;
    end
    chk({15'h0, irq_ack}, 16'h0001);
    // the request is taken at this edge and dropped before the next one
    @(posedge core_clk);
    @(negedge core_clk);
    irq_req = 1'b0;
    wait_idle();
    chk(word_memory_i.words[255], 16'h0000);
    chk(word_memory_i.words[254], 16'h0202);
    chk(pc_q, 16'h0300);
    chk(psw, 16'hC800);
    chk({13'h0, run_mode, reg_set}, 16'h0007);
    chk(sp_q, 16'hFFFC);
    issue(`OP_SERVICE_RT, 3'h0, 16'h0000);
    chk(pc_q, 16'h0202);
    chk(psw, 16'h0000);
    chk(sp_q, 16'h0000);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // main sequence
  initial
  begin
    rstn = 1'b0;
    {op_valid, irq_req, op_code, op_reg} = 8'h00;
    op_target = 16'h0000;
    irq_vector = 16'h0000;
    mem_delay = 4'h0;
    repeat (20) @(negedge core_clk);
    rstn = 1'b1;
    wait_idle();
    t_jump();
    t_call();
    t_irq();
    complete_run();
  end
endmodule
